// >>> verif/flash_command_protect_ctrl_assertions.sv
// port checks for the flash command sequencer
// assumes binding from tb, one clock domain
`timescale 1ns/1ns
module flash_command_protect_ctrl_assertions (
	input wire logic                     core_clk,
	input wire logic                     reset_n,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [7:0]               paddr,
	input wire logic [31:0]              pwdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire logic                     stopMode,
	input wire flash_seq_pkg::flash_op_s flashOp
);
	// ==========================================
	// properties
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_answer: assert property (psel && penable && !$past(penable) |=> pready)
		else $error("no answer after access phase");
	a_unmapped_error: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
		else $error("pslverr wrong for address");
	a_launch_cause: assert property ($rose(flashOp.active) |-> $past(pwrite && pready && paddr == 8'h08))
		else $error("run started without launch write");
	a_stop_abort: assert property (flashOp.active && stopMode |=> !flashOp.active)
		else $error("run survived stop mode");
	a_code_known: assert property (flashOp.active |-> flashOp.cmd inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
		else $error("unknown command running");
	a_addr_range: assert property (flashOp.active |-> flashOp.addr < 16'hc000)
		else $error("run outside array");
	a_run_hold: assert property ($rose(flashOp.active) && flashOp.cmd == 8'h20 && !stopMode |-> flashOp.active [*8])
		else $error("byte program ended early");
	c_launch: cover property ($rose(flashOp.active));
	c_abort: cover property (flashOp.active && stopMode);
	c_unmapped: cover property (pready && pslverr);
endmodule : flash_command_protect_ctrl_assertions

// >>> verif/flash_host_model.sv
// apb host standing in for the cpu or debug controller
// assumes the slave answers with pready on core_clk
`timescale 1ns/1ns
module flash_host_model (
	input  wire logic        core_clk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic             debugAccess
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'hff;
		pwdata = 32'h0;
		debugAccess = 1'b0;
	end
	// ==========================================
	// one transfer, held until pready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic dbg,
		output logic [31:0] r, output logic err);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		debugAccess <= dbg;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released bus shows junk, not the old value
		paddr <= ~a;
		pwdata <= ~d;
		debugAccess <= 1'b0;
	endtask : xfer
	// ==========================================
	// address, command, launch
	task automatic issue(input logic [15:0] ad, input logic [7:0] dt, input logic [7:0] cmd, input logic dbg);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, 8'h10, {8'h00, dt, ad}, dbg, r, e);
		xfer(1'b1, 8'h0c, {24'h0, cmd}, dbg, r, e);
		xfer(1'b1, 8'h08, 32'h80, dbg, r, e);
	endtask : issue
endmodule : flash_host_model

// >>> verif/tb.sv
// self-checking bench for the flash command sequencer
// assumes host model on apb, checker bound at the foot
`timescale 1ns/1ns
module tb;
	// ==========================================
	// signals
	logic                     core_clk;
	logic                     reset_n;
	logic                     psel;
	logic                     penable;
	logic                     pwrite;
	logic [7:0]               paddr;
	logic [31:0]              pwdata;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	logic                     debugAccess;
	logic                     chipSecured;
	logic                     stopMode;
	logic [7:0]               nvProtByte;
	logic [7:0]               protNow = 8'h50;
	flash_seq_pkg::flash_op_s flashOp;
	int                       failures = 0;
	int                       tests_run = 0;
	int                       cycles = 0;
	flash_host_model host (.core_clk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata,
		.debugAccess);
	flash_command_protect_ctrl dut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .debugAccess, .chipSecured, .stopMode, .nvProtByte, .flashOp);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			summarize();
		end
	end
	// ==========================================
	// expectations and checks
	function automatic int ticksFor(input logic [7:0] cmd);
		return cmd == 8'h05 ? 1 : cmd == 8'h20 ? 9 : 4;
	endfunction : ticksFor
	function automatic logic isBlocked(input logic [7:0] p, input logic [7:0] cmd, input logic [15:0] ad);
		return !p[7] && cmd != 8'h05 && (cmd == 8'h41 || ad[15:9] >= p[6:0]);
	endfunction : isBlocked
	task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		host.xfer(1'b1, a, d, 1'b0, r, e);
	endtask : wr
	task automatic regIs(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
		logic [31:0] r;
		logic        e;
		host.xfer(1'b0, a, 32'h0, 1'b0, r, e);
		check("register", {25'h0, exp}, {25'h0, r[7:0] & mask});
	endtask : regIs
	task automatic errCase(input logic [7:0] a2, input logic [7:0] d2, input logic [7:0] a3, input logic [7:0] d3);
		wr(8'h10, 32'h0200);
		wr(a2, {24'h0, d2});
		if (a3 != 8'hff) begin
			wr(a3, {24'h0, d3});
		end
		regIs(8'h08, 8'h10, 8'h10);
		wr(8'h08, 32'h10);
		regIs(8'h08, 8'h90, 8'h80);
	endtask : errCase
	task automatic runOp(input logic [15:0] ad, input logic [7:0] dt, input logic [7:0] cmd);
		int cnt;
		int t;
		t = ticksFor(cmd);
		cnt = 0;
		host.issue(ad, dt, cmd, 1'b0);
		// first negedge after the launch edge: a one-tick run may end at the next edge
		@(negedge core_clk);
		if (isBlocked(protNow, cmd, ad)) begin
			check("op idle", 33'h0, {32'h0, flashOp.active});
			regIs(8'h08, 8'h30, 8'h20);
			wr(8'h08, 32'h20);
		end else begin
			check("op fields", {1'b1, cmd, ad, dt}, flashOp);
			while (flashOp.active === 1'b1 && cnt < 5000) begin
				@(negedge core_clk);
				cnt++;
			end
			check("op length", 33'h1, {32'h0, cnt > (t - 1) * 160 && cnt <= t * 160});
			regIs(8'h08, 8'hf0, 8'hc0);
		end
	endtask : runOp
	task automatic summarize();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	// ==========================================
	// main sequence
	initial begin
		logic [31:0] r;
		logic        e;
		logic [7:0]  codes [3] = '{8'h20, 8'h25, 8'h40};
		reset_n = 1'b0;
		stopMode = 1'b0;
		chipSecured = 1'b0;
		nvProtByte = 8'h50;
		r = $urandom(55067);
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		regIs(8'h04, 8'hff, 8'h50);
		wr(8'h04, 32'hff);
		regIs(8'h04, 8'hff, 8'h50);
		wr(8'h10, 32'h0);
		regIs(8'h08, 8'h10, 8'h10);
		wr(8'h00, 32'h53);
		regIs(8'h00, 8'hff, 8'h00);
		wr(8'h08, 32'h10);
		regIs(8'h08, 8'h10, 8'h00);
		// 8 * 20 cycles of 40 ns gives about 156 kHz
		wr(8'h00, 32'h53);
		wr(8'h00, 32'h01);
		regIs(8'h00, 8'hff, 8'hd3);
		host.xfer(1'b0, 8'h14, 32'h0, 1'b0, r, e);
		check("slave error", 33'h1, {32'h0, e});
		runOp(16'h9fff, 8'ha5, 8'h20);
		runOp(16'ha000, 8'h5a, 8'h20);
		runOp(16'h0000, 8'h00, 8'h41);
		runOp(16'h0200, 8'h00, 8'h05);
		runOp(16'($urandom_range(0, 40959)), 8'($urandom), 8'h25);
		repeat (3) runOp(16'($urandom_range(0, 40959)), 8'($urandom), 8'h20);
		errCase(8'h0c, 8'h21, 8'hff, 8'h00);
		errCase(8'h10, 8'h00, 8'hff, 8'h00);
		errCase(8'h0c, 8'h20, 8'h0c, 8'h20);
		errCase(8'h08, 8'h80, 8'hff, 8'h00);
		errCase(8'h0c, 8'h20, 8'h00, 8'h01);
		errCase(8'h0c, 8'h20, 8'h08, 8'h00);
		chipSecured <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			host.issue(16'h0200, 8'h11, codes[i], 1'b1);
			regIs(8'h08, 8'h10, 8'h10);
			wr(8'h08, 32'h10);
		end
		chipSecured <= 1'b0;
		host.xfer(1'b1, 8'h04, 32'h80, 1'b1, r, e);
		protNow = 8'h80;
		regIs(8'h04, 8'hff, 8'h80);
		for (int i = 0; i < 2; i++) begin
			host.issue(16'h0000, 8'h00, 8'h41, 1'b0);
			if (i == 0) begin
				wr(8'h10, 32'h0400);
				regIs(8'h08, 8'h90, 8'h10);
			end
			// launch lands at the edge issue returns on, so let it settle
			@(posedge core_clk);
			check("mass running", 33'h1, {32'h0, flashOp.active});
			stopMode <= 1'b1;
			repeat (3) @(posedge core_clk);
			stopMode <= 1'b0;
			check("op aborted", 33'h0, {32'h0, flashOp.active});
			regIs(8'h08, 8'h10, 8'h10);
			wr(8'h08, 32'h10);
		end
		// second reset: protection reloads, divider opens again
		reset_n <= 1'b0;
		nvProtByte <= 8'h3c;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		regIs(8'h04, 8'hff, 8'h3c);
		regIs(8'h00, 8'hff, 8'h00);
		summarize();
	end
endmodule : tb
bind flash_command_protect_ctrl flash_command_protect_ctrl_assertions chk (.core_clk, .reset_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .stopMode, .flashOp);

// >>> verilog/flash_command_protect_ctrl.sv
// flash command sequencer with access errors and block protection
// assumes apb master on core_clk; array engine follows flashOp
`timescale 1ns/1ns
module flash_command_protect_ctrl (
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       debugAccess,
	input  wire logic                       chipSecured,
	input  wire logic                       stopMode,
	input  wire logic [7:0]                 nvProtByte,
	output flash_seq_pkg::flash_op_s        flashOp
);
	typedef struct packed {
		flash_seq_pkg::seq_state_e state;
		logic                      protLoaded;
		logic [7:0]                prot;
		logic                      divDone;
		logic                      pre8;
		logic [5:0]                divide;
		logic                      accErr;
		logic                      protViol;
		logic                      complete;
		logic [15:0]               ticks;
		flash_seq_pkg::flash_op_s  op;
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
	} ctrl_s;

	ctrl_s       s;
	ctrl_s       next_s;
	logic        tick;
	logic        blocked;
	logic        mapped;
	logic        wrDone;
	logic        errEvt;
	logic        errClear;
	logic        pendCmd;
	logic [31:0] readData;
	logic [7:0]  wrByte;

	// ==========================================
	// helpers
	function automatic logic validCmd(input logic [7:0] code);
		validCmd = code == flash_seq_pkg::CMD_BLANK || code == flash_seq_pkg::CMD_BYTE
			|| code == flash_seq_pkg::CMD_BURST || code == flash_seq_pkg::CMD_PAGE
			|| code == flash_seq_pkg::CMD_MASS;
	endfunction : validCmd

	function automatic logic [15:0] cmdTicks(input logic [7:0] code);
		unique case (code)
			flash_seq_pkg::CMD_BYTE:  cmdTicks = flash_seq_pkg::TICKS_BYTE;
			flash_seq_pkg::CMD_BURST: cmdTicks = flash_seq_pkg::TICKS_BURST;
			flash_seq_pkg::CMD_PAGE:  cmdTicks = flash_seq_pkg::TICKS_PAGE;
			flash_seq_pkg::CMD_MASS:  cmdTicks = flash_seq_pkg::TICKS_MASS;
			default:                  cmdTicks = flash_seq_pkg::TICKS_BLANK;
		endcase
	endfunction : cmdTicks

	// ==========================================
	// submodules
	flash_timing_tick timer (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.enable   (s.divDone),
		.pre8     (s.pre8),
		.divide   (s.divide),
		.tick     (tick)
	);

	flash_protect_check protect (
		.prot    (s.prot),
		.cmd     (s.op.cmd),
		.addr    (s.op.addr),
		.blocked (blocked)
	);

	// ==========================================
	// register read mux
	always_comb begin
		mapped = 1'b1;
		readData = 32'h0000_0000;
		unique case (paddr)
			flash_seq_pkg::OFS_DIVIDER: readData[7:0] = {s.divDone, s.pre8, s.divide};
			flash_seq_pkg::OFS_PROT:    readData[7:0] = s.prot;
			flash_seq_pkg::OFS_STATUS:  readData[7:0] = {s.state == flash_seq_pkg::SEQ_IDLE,
				s.complete, s.protViol, s.accErr, 4'h0};
			flash_seq_pkg::OFS_CMD:     readData[7:0] = s.op.cmd;
			flash_seq_pkg::OFS_ARRAY:   readData = {8'h00, s.op.data, s.op.addr};
			default:                    mapped = 1'b0;
		endcase
	end

	// ==========================================
	// sequencer
	always_comb begin
		next_s = s;
		errEvt = 1'b0;
		errClear = 1'b0;
		wrByte = pwdata[7:0];
		pendCmd = s.state == flash_seq_pkg::SEQ_ADDR || s.state == flash_seq_pkg::SEQ_CMD;
		// writes take effect only at the edge that completes the access
		wrDone = psel && penable && s.pready && pwrite && mapped;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		if (psel && penable && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.pslverr = !mapped;
			next_s.prdata = pwrite ? 32'h0000_0000 : readData;
		end
		if (!s.protLoaded) begin
			next_s.protLoaded = 1'b1;
			next_s.prot = nvProtByte;
		end
		if (wrDone) begin
			unique case (paddr)
				flash_seq_pkg::OFS_DIVIDER: begin
					if (pendCmd) begin
						errEvt = 1'b1;
					end else if (!s.divDone && !s.accErr) begin
						next_s.divDone = 1'b1;
						next_s.pre8 = wrByte[flash_seq_pkg::DIV_PRE8_BIT];
						next_s.divide = wrByte[5:0];
					end
				end
				flash_seq_pkg::OFS_PROT: begin
					if (pendCmd) begin
						errEvt = 1'b1;
					end else if (debugAccess) begin
						next_s.prot = wrByte;
					end
				end
				flash_seq_pkg::OFS_STATUS: begin
					errClear = wrByte[flash_seq_pkg::ST_ACCERR_BIT];
					if (wrByte[flash_seq_pkg::ST_PVIOL_BIT]) begin
						next_s.protViol = 1'b0;
					end
					if (pendCmd && !wrByte[flash_seq_pkg::ST_CBE_BIT]) begin
						errEvt = 1'b1;
					end else if (s.state == flash_seq_pkg::SEQ_ADDR) begin
						errEvt = 1'b1;
					end else if (s.state == flash_seq_pkg::SEQ_CMD) begin
						if (blocked) begin
							next_s.protViol = 1'b1;
							next_s.state = flash_seq_pkg::SEQ_IDLE;
						end else begin
							next_s.state = flash_seq_pkg::SEQ_RUN;
							next_s.ticks = cmdTicks(s.op.cmd);
							next_s.op.active = 1'b1;
							next_s.complete = 1'b0;
						end
					end
				end
				flash_seq_pkg::OFS_CMD: begin
					if (s.accErr) begin
						next_s.state = s.state;
					end else if (s.state != flash_seq_pkg::SEQ_ADDR) begin
						errEvt = 1'b1;
					end else if (!validCmd(wrByte)) begin
						errEvt = 1'b1;
					end else if (debugAccess && chipSecured && wrByte != flash_seq_pkg::CMD_BLANK
						&& wrByte != flash_seq_pkg::CMD_MASS) begin
						errEvt = 1'b1;
					end else begin
						next_s.op.cmd = wrByte;
						next_s.state = flash_seq_pkg::SEQ_CMD;
					end
				end
				default: begin
					if (s.accErr) begin
						next_s.state = s.state;
					end else if (!s.divDone) begin
						errEvt = 1'b1;
					end else if (s.state == flash_seq_pkg::SEQ_RUN) begin
						errEvt = 1'b1;
					end else if (pendCmd) begin
						errEvt = 1'b1;
					end else if (pwdata[15:0] >= 16'(flash_seq_pkg::ARRAY_BYTES)) begin
						errEvt = 1'b1;
					end else begin
						next_s.op.addr = pwdata[15:0];
						next_s.op.data = pwdata[flash_seq_pkg::ARR_DATA_LSB +: 8];
						next_s.state = flash_seq_pkg::SEQ_ADDR;
					end
				end
			endcase
		end
		if (s.state == flash_seq_pkg::SEQ_RUN) begin
			if (stopMode) begin
				errEvt = 1'b1;
				next_s.op.active = 1'b0;
				next_s.state = flash_seq_pkg::SEQ_IDLE;
			end else if (tick) begin
				// length counted only in timing periods, never bus cycles
				if (s.ticks == 16'h0001) begin
					next_s.op.active = 1'b0;
					next_s.complete = 1'b1;
					next_s.state = flash_seq_pkg::SEQ_IDLE;
				end else begin
					next_s.ticks = s.ticks - 16'h0001;
				end
			end
		end
		// an error drops any half-entered command; a running one continues unless stop mode aborted it
		if (errEvt && pendCmd) begin
			next_s.state = flash_seq_pkg::SEQ_IDLE;
		end
		// set wins over a clear in the same cycle
		next_s.accErr = (s.accErr && !errClear) || errEvt;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '{state: flash_seq_pkg::SEQ_IDLE, prot: flash_seq_pkg::PROT_RESET,
				divide: flash_seq_pkg::DIV_RESET, default: '0};
		end else begin
			s <= next_s;
		end
	end

	// ==========================================
	// outputs
	assign prdata  = s.prdata;
	assign pready  = s.pready;
	assign pslverr = s.pslverr;
	assign flashOp = s.op;
endmodule : flash_command_protect_ctrl

// >>> verilog/flash_protect_check.sv
// protection decode for a launched command
// assumes address and command held stable by the sequencer
`timescale 1ns/1ns
module flash_protect_check (
	input  wire logic [7:0]  prot,
	input  wire logic [7:0]  cmd,
	input  wire logic [15:0] addr,
	output logic             blocked
);
	logic protOn;
	logic inRange;

	// ==========================================
	// region decode
	// field zero covers every page, so whole array protection
	assign protOn  = !prot[flash_seq_pkg::PROT_DIS_BIT];
	assign inRange = protOn && (addr[15:flash_seq_pkg::PAGE_LSB] >= prot[6:0]);

	always_comb begin
		unique case (cmd)
			flash_seq_pkg::CMD_MASS:  blocked = protOn;
			flash_seq_pkg::CMD_BLANK: blocked = 1'b0;
			default:                  blocked = inRange;
		endcase
	end
endmodule : flash_protect_check

// >>> verilog/flash_seq_pkg.sv
// constants, types and layouts of the flash command sequencer
// assumes one bus clock and an apb master on the register side
// Behaviour
// - divider register accepts only first write
// - divider write blocked while access error set
// - operations timed in whole timing clock periods
// - access error is write-one-clear, blocks commands
// - array write before divider sets error
// - array write while buffer busy sets error
// - second array write before launch sets error
// - second command write before launch sets error
// - non-command control write after array write errors
// - only five command codes accepted
// - after command only status launch write allowed
// - stop mode aborts running command with error
// - secured debug may only blank check, mass erase
// - writing zero to buffer-empty flag errors while a command is pending
// - protected addresses reject program and erase
// - mass erase disabled when anything protected
// - protection: disable bit plus 7-bit lowest protected page
// - protected region is top block or whole array
// - protection loaded from nonvolatile byte at reset
// - only debug accesses write protection register
// - array is 96 pages of 512 bytes
package flash_seq_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] OFS_DIVIDER = 8'h00;
	localparam logic [7:0] OFS_PROT    = 8'h04;
	localparam logic [7:0] OFS_STATUS  = 8'h08;
	localparam logic [7:0] OFS_CMD     = 8'h0c;
	localparam logic [7:0] OFS_ARRAY   = 8'h10;
	// ==========================================
	// field positions
	localparam int DIV_PRE8_BIT  = 6;
	localparam int DIV_DONE_BIT  = 7;
	localparam int PROT_DIS_BIT  = 7;
	localparam int ST_CBE_BIT    = 7;
	localparam int ST_CCF_BIT    = 6;
	localparam int ST_PVIOL_BIT  = 5;
	localparam int ST_ACCERR_BIT = 4;
	localparam int ARR_DATA_LSB  = 16;
	// ==========================================
	// reset values
	localparam logic [7:0] PROT_RESET = 8'hff;
	localparam logic [5:0] DIV_RESET  = 6'h00;
	// ==========================================
	// array geometry
	localparam int ARRAY_BYTES = 49152;
	localparam int PAGE_BYTES  = 512;
	localparam int PAGE_COUNT  = 96;
	localparam int PAGE_LSB    = $clog2(PAGE_BYTES);
	// ==========================================
	// command codes
	localparam logic [7:0] CMD_BLANK = 8'h05;
	localparam logic [7:0] CMD_BYTE  = 8'h20;
	localparam logic [7:0] CMD_BURST = 8'h25;
	localparam logic [7:0] CMD_PAGE  = 8'h40;
	localparam logic [7:0] CMD_MASS  = 8'h41;
	// ==========================================
	// operation lengths in timing clock periods
	localparam logic [15:0] TICKS_BLANK = 16'h0001;
	localparam logic [15:0] TICKS_BYTE  = 16'h0009;
	localparam logic [15:0] TICKS_BURST = 16'h0004;
	localparam logic [15:0] TICKS_PAGE  = 16'h0fa0;
	localparam logic [15:0] TICKS_MASS  = 16'h4e20;
	localparam int PRE8_DIVIDE = 8;
	// ==========================================
	// types
	typedef enum logic [3:0] {
		SEQ_IDLE = 4'h1,
		SEQ_ADDR = 4'h2,
		SEQ_CMD  = 4'h4,
		SEQ_RUN  = 4'h8
	} seq_state_e;
	typedef struct packed {
		logic        active;
		logic [7:0]  cmd;
		logic [15:0] addr;
		logic [7:0]  data;
	} flash_op_s;
endpackage : flash_seq_pkg

// >>> verilog/flash_timing_tick.sv
// timing clock generator: one-cycle tick per timing period
// assumes divider settings stay stable once enabled
`timescale 1ns/1ns
module flash_timing_tick (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       enable,
	input  wire logic       pre8,
	input  wire logic [5:0] divide,
	output logic            tick
);
	typedef struct packed {
		logic [2:0] pre;
		logic [5:0] cnt;
		logic       tick;
	} tick_s;
	tick_s s;
	tick_s next_s;
	logic  preDone;

	// ==========================================
	// prescaler then divider
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		preDone = !pre8 || s.pre == 3'(flash_seq_pkg::PRE8_DIVIDE - 1);
		if (!enable) begin
			next_s.pre = 3'h0;
			next_s.cnt = 6'h00;
		end else begin
			next_s.pre = preDone ? 3'h0 : s.pre + 3'h1;
			if (preDone) begin
				if (s.cnt == divide) begin
					next_s.cnt = 6'h00;
					next_s.tick = 1'b1;
				end else begin
					next_s.cnt = s.cnt + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;
endmodule : flash_timing_tick
